//--- include/tcba_pkg.sv
// How it works
// RULE1: Each timer count is 16 bits, read as a high byte and a low byte.
// RULE2: Reading the high byte while enabled copies the low byte into a holding register.
// RULE3: Reading the low byte while enabled returns the holding register.
// RULE4: Reading the low byte while disabled returns the live low byte.
// RULE5: A byte write loads that counter byte at the next clock edge.
// RULE6: After a byte write the counter keeps counting from the new value.
// RULE7: No write holding register; each byte write acts alone.
// RULE8: Software should avoid writing count bytes while the timer runs.
// RULE9: A disabled timer holds its count; counting resumes from the written value.
package tcba_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_T0_HIGH = 12'hF00;
  localparam logic [11:0] IDX_T0_LOW  = 12'hF01;
  localparam logic [11:0] IDX_T1_HIGH = 12'hF08;
  localparam logic [11:0] IDX_T1_LOW  = 12'hF09;
  localparam logic [11:0] IDX_STATUS  = 12'hF10;

  localparam int          ADDR_W      = 16;
  localparam int          DATA_W      = 32;
  localparam int          CNT_W       = 16;
  localparam int          BYTE_W      = 8;
  localparam int          NUM_TMR     = 2;

  // Reset values
  localparam logic [7:0]  RST_HIGH    = 8'h00;
  localparam logic [7:0]  RST_LOW     = 8'h01;
  localparam logic [15:0] RST_COUNT   = {RST_HIGH, RST_LOW};

  // Status register field positions
  localparam int          STAT_EN0    = 0;
  localparam int          STAT_EN1    = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Decoded register selection
  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_T0H  = 3'h1,
    SEL_T0L  = 3'h3,
    SEL_T1H  = 3'h2,
    SEL_T1L  = 3'h6,
    SEL_STAT = 3'h7
  } tcba_sel_t;

  function automatic logic [15:0] idx2addr(input logic [11:0] idx);
    idx2addr = {2'h0, idx, 2'h0};
  endfunction

  // Used for both the read phase and the write completion
  function automatic tcba_sel_t reg_sel(input logic [15:0] addr);
    if (addr == idx2addr(IDX_T0_HIGH)) begin
      reg_sel = SEL_T0H;
    end else if (addr == idx2addr(IDX_T0_LOW)) begin
      reg_sel = SEL_T0L;
    end else if (addr == idx2addr(IDX_T1_HIGH)) begin
      reg_sel = SEL_T1H;
    end else if (addr == idx2addr(IDX_T1_LOW)) begin
      reg_sel = SEL_T1L;
    end else if (addr == idx2addr(IDX_STATUS)) begin
      reg_sel = SEL_STAT;
    end else begin
      reg_sel = SEL_NONE;
    end
  endfunction

endpackage

//--- include/tcba_tmr_if.sv
`timescale 1ns/1ns
// Signals between the bus front end and one timer's count logic
interface tcba_tmr_if;
  logic        en;        // Timer enabled
  logic        inc;       // Count step from counting engine
  logic        wr_high;   // Write high byte, one cycle
  logic        wr_low;    // Write low byte, one cycle
  logic [7:0]  wdata;     // Byte being written
  logic        rd_high;   // High byte read, one cycle
  logic [15:0] count;     // Live count
  logic [7:0]  low_rd;    // Value a low byte read returns

  modport ctl  (output en, inc, wr_high, wr_low, wdata, rd_high, input count, low_rd);
  modport cnt  (input en, inc, wr_high, wr_low, wdata, output count);
  modport hold (input en, rd_high, count, output low_rd);
endinterface

//--- rtl/tcba_count.sv
`timescale 1ns/1ns
module tcba_count (
  input  wire logic  pclk,
  input  wire logic  presetn,
  tcba_tmr_if.cnt    tif
);

  typedef struct packed {
    logic [15:0] count;
  } tcba_cnt_st_t;

  tcba_cnt_st_t s_q;
  tcba_cnt_st_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Byte writes win over the step in that cycle; the other byte is kept
  always_comb begin
    s_d = s_q;
    if (tif.wr_high || tif.wr_low) begin
      if (tif.wr_high) begin
        s_d.count[15:8] = tif.wdata;  // [RULE5] [RULE7]
      end
      if (tif.wr_low) begin
        s_d.count[7:0] = tif.wdata;   // [RULE5] [RULE7]
      end
    end else if (tif.en && tif.inc) begin
      s_d.count = s_q.count + 16'h0001; // Continues from new value [RULE6]
    end
    // Disabled: no step, count stays as written [RULE9]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{count: tcba_pkg::RST_COUNT};
    end else begin
      s_q <= s_d;
    end
  end

  assign tif.count = s_q.count; // [RULE1]

endmodule

//--- rtl/tcba_hold.sv
`timescale 1ns/1ns
module tcba_hold (
  input  wire logic  pclk,
  input  wire logic  presetn,
  tcba_tmr_if.hold   tif
);

  typedef struct packed {
    logic [7:0] low_hold;
  } tcba_hold_st_t;

  tcba_hold_st_t s_q;
  tcba_hold_st_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Capture low byte on a high byte read, only while running
  always_comb begin
    s_d = s_q;
    if (tif.en && tif.rd_high) begin
      s_d.low_hold = tif.count[7:0]; // [RULE2]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{low_hold: tcba_pkg::RST_LOW};
    end else begin
      s_q <= s_d;
    end
  end

  // Stale until first high read; software reads high first
  assign tif.low_rd = tif.en ? s_q.low_hold    // [RULE3]
                             : tif.count[7:0]; // [RULE4]

endmodule

//--- rtl/tcba_top.sv
`timescale 1ns/1ns
module tcba_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  tmr_en,
  input  wire logic [1:0]  tmr_inc,
  output logic      [15:0] tmr_count0,
  output logic      [15:0] tmr_count1
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end state
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tcba_top_st_t;

  tcba_top_st_t s_q;
  tcba_top_st_t s_d;

  tcba_pkg::tcba_sel_t sel;
  logic                setup;
  logic                done;
  logic                wr_ok;
  logic [15:0]         cnt_w [tcba_pkg::NUM_TMR];
  logic [7:0]          low_w [tcba_pkg::NUM_TMR];
  logic [1:0]          rd_high_w;
  logic [1:0]          wr_high_w;
  logic [1:0]          wr_low_w;

  tcba_tmr_if tif [tcba_pkg::NUM_TMR] ();

  ////////////////////////////////////////////////////////////////////////////
  // Phase decode; read side effects at setup, writes at completion
  assign sel   = tcba_pkg::reg_sel(paddr);
  assign setup = psel && !penable;
  assign done  = psel && penable && s_q.pready;
  assign wr_ok = done && pwrite && pstrb[0];

  // Capturing at setup keeps returned byte and held byte in step
  assign rd_high_w[0] = setup && !pwrite && (sel == tcba_pkg::SEL_T0H); // [RULE2]
  assign rd_high_w[1] = setup && !pwrite && (sel == tcba_pkg::SEL_T1H); // [RULE2]
  assign wr_high_w[0] = wr_ok && (sel == tcba_pkg::SEL_T0H);
  assign wr_high_w[1] = wr_ok && (sel == tcba_pkg::SEL_T1H);
  assign wr_low_w[0]  = wr_ok && (sel == tcba_pkg::SEL_T0L);
  assign wr_low_w[1]  = wr_ok && (sel == tcba_pkg::SEL_T1L);

  ////////////////////////////////////////////////////////////////////////////
  // Per-timer count and holding logic
  for (genvar i = 0; i < tcba_pkg::NUM_TMR; i++) begin : g_tmr
    assign tif[i].en      = tmr_en[i];
    assign tif[i].inc     = tmr_inc[i];
    assign tif[i].wr_high = wr_high_w[i];
    assign tif[i].wr_low  = wr_low_w[i];
    assign tif[i].wdata   = pwdata[7:0];
    assign tif[i].rd_high = rd_high_w[i];
    assign cnt_w[i]       = tif[i].count;
    assign low_w[i]       = tif[i].low_rd;

    tcba_count u_count (
      .pclk    (pclk),
      .presetn (presetn),
      .tif     (tif[i])
    );

    tcba_hold u_hold (
      .pclk    (pclk),
      .presetn (presetn),
      .tif     (tif[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // No wait state: pready rises in the first access cycle
  always_comb begin
    s_d         = s_q;
    s_d.pready  = setup;
    s_d.pslverr = setup && (sel == tcba_pkg::SEL_NONE);
    if (setup && !pwrite) begin
      unique case (sel)
        tcba_pkg::SEL_T0H:  s_d.prdata = {24'h000000, cnt_w[0][15:8]}; // [RULE1]
        tcba_pkg::SEL_T0L:  s_d.prdata = {24'h000000, low_w[0]};       // [RULE3] [RULE4]
        tcba_pkg::SEL_T1H:  s_d.prdata = {24'h000000, cnt_w[1][15:8]}; // [RULE1]
        tcba_pkg::SEL_T1L:  s_d.prdata = {24'h000000, low_w[1]};       // [RULE3] [RULE4]
        tcba_pkg::SEL_STAT: s_d.prdata = {30'h0, tmr_en};
        tcba_pkg::SEL_NONE: s_d.prdata = 32'h00000000;
      endcase
    end else if (setup) begin
      s_d.prdata = 32'h00000000; // Writes read back zero
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{prdata: 32'h00000000, pready: 1'b0, pslverr: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata     = s_q.prdata;
  assign pready     = s_q.pready;
  assign pslverr    = s_q.pslverr;
  assign tmr_count0 = cnt_w[0];
  assign tmr_count1 = cnt_w[1];

endmodule

//--- testbench/tcba_assertions.sv
`timescale 1ns/1ns
module tcba_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  tmr_en,
  input wire logic [1:0]  tmr_inc,
  input wire logic [15:0] tmr_count0,
  input wire logic [15:0] tmr_count1
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       wr;
  logic       rs;
  logic [7:0] hold_q;
  // Access phase of a write, setup of a read
  assign wr = psel && penable && pwrite;
  assign rs = psel && !penable && !pwrite;
  // Shadow latch; reset value matters for a low read before any high read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 8'h01;
    end else if (rs && paddr == 16'h3C00 && tmr_en[0]) begin
      hold_q <= tmr_count0[7:0];
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  property p_hold; !tmr_en[0] && !wr |=> $stable(tmr_count0); endproperty
  a_hold: assert property (p_hold) else $error("count moved while off");
  property p_step0; tmr_en[0] && tmr_inc[0] && !wr |=> tmr_count0 == $past(tmr_count0) + 16'h1; endproperty
  a_step0: assert property (p_step0) else $error("timer 0 step wrong");
  property p_step1; tmr_en[1] && tmr_inc[1] && !wr |=> tmr_count1 == $past(tmr_count1) + 16'h1; endproperty
  a_step1: assert property (p_step1) else $error("timer 1 step wrong");
  property p_wrh; wr && pready && pstrb[0] && paddr == 16'h3C00 |=> tmr_count0[15:8] == $past(pwdata[7:0]); endproperty
  a_wrh: assert property (p_wrh) else $error("high write lost");
  property p_wrl; wr && pready && pstrb[0] && paddr == 16'h3C04 |=>
    tmr_count0 == {$past(tmr_count0[15:8]), $past(pwdata[7:0])}; endproperty
  a_wrl: assert property (p_wrl) else $error("low write wrong");
  property p_rdh; rs && paddr == 16'h3C00 |=> pready && prdata == {24'h0, $past(tmr_count0[15:8])}; endproperty
  a_rdh: assert property (p_rdh) else $error("high read wrong");
  property p_rdl; rs && paddr == 16'h3C04 && !tmr_en[0] |=> prdata == {24'h0, $past(tmr_count0[7:0])}; endproperty
  a_rdl: assert property (p_rdl) else $error("direct low read wrong");
  property p_rdlh; rs && paddr == 16'h3C04 && tmr_en[0] |=> prdata == {24'h0, $past(hold_q)}; endproperty
  a_rdlh: assert property (p_rdlh) else $error("latched low read wrong");
endmodule

//--- testbench/test_timer_count_byte_access.sv
`timescale 1ns/1ns
module test_timer_count_byte_access;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready, pslverr;
  logic [1:0]  tmr_en = 2'h0, tmr_inc = 2'h0;
  logic [15:0] tmr_count0, tmr_count1;
  int          miscompares = 0, total_checks = 0, cycles = 0;
  tcba_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tmr_en(tmr_en), .tmr_inc(tmr_inc), .tmr_count0(tmr_count0), .tmr_count1(tmr_count1));
  // Clock and a hang guard
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      wrap_up();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    chk({31'h0, pslverr}, {31'h0, a == 16'h1000});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    logic [31:0] r;
    apb(1'b0, a, 8'h00, r);
    chk(r, {24'h0, e});
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, both timers, plus an unmapped place
    rd(16'h3C00, 8'h00);
    rd(16'h3C04, 8'h01);
    rd(16'h3C20, 8'h00);
    rd(16'h3C24, 8'h01);
    rd(16'h1000, 8'h00);
    $display("reset test done");
    // Bytes land separately on a stopped timer
    // Writing only while stopped keeps software on the safe side
    wr(16'h3C00, 8'h12);
    @(posedge pclk);
    chk({16'h0, tmr_count0}, 32'h1201);
    wr(16'h3C04, 8'h34);
    repeat (3) @(posedge pclk);
    chk({16'h0, tmr_count0}, 32'h1234);
    $display("stopped write test done");
    // Latch on high read; a later low write is hidden until stopped
    tmr_en <= 2'h1;
    rd(16'h3C00, 8'h12);
    wr(16'h3C04, 8'h56);
    rd(16'h3C04, 8'h34);
    tmr_en <= 2'h0;
    rd(16'h3C04, 8'h56);
    $display("latch test done");
    // Write while counting, then carry through the low byte
    tmr_en <= 2'h2;
    wr(16'h3C24, 8'hFF);
    pstrb <= 4'h0;
    wr(16'h3C20, 8'h77);
    pstrb <= 4'hF;
    chk({16'h0, tmr_count1}, 32'h00FF);
    tmr_inc <= 2'h3; // Timer 0 is offered steps while stopped
    repeat (3) @(posedge pclk);
    tmr_inc <= 2'h0;
    @(posedge pclk);
    chk({16'h0, tmr_count1}, 32'h0102);
    chk({16'h0, tmr_count0}, 32'h1256);
    $display("counting test done");
    // Latch on timer 1, status readback, then timer 0 steps
    rd(16'h3C20, 8'h01);
    rd(16'h3C24, 8'h02);
    tmr_en <= 2'h3;
    rd(16'h3C40, 8'h03);
    tmr_inc <= 2'h1;
    repeat (2) @(posedge pclk);
    tmr_inc <= 2'h0;
    @(posedge pclk);
    chk({16'h0, tmr_count0}, 32'h1258);
    $display("timer 1 latch test done");
    wrap_up();
  end
endmodule
bind tcba_top tcba_assertions chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .tmr_en(tmr_en), .tmr_inc(tmr_inc), .tmr_count0(tmr_count0), .tmr_count1(tmr_count1));
